// [dv/testbench.sv]
// Self-checking testbench for the vectored interrupt arbiter.
`timescale 1ns/10ps
module testbench;
    localparam logic [14:0] MEM_TOP = 15'h3FFF;
    logic ref_clk_i, rst_i, icyc, ir_load, vs, clr, pop, global_irq_enable, pm_valid, pm_rd, take, ack, gie_clr, pc_load, busy;
    logic [7:0] ir_byte, sp, pm_data, pm_byte;
    logic [14:0] pc_i, op_addr, pm_addr, push_addr, pc_o;
    logic [3:0] lat;
    via_pkg::via_src_t pend, enb;
    int fail_count, cmp_count;
    logic [7:0] offs [7] = '{8'hFA, 8'hF8, 8'hF6, 8'hF4, 8'hF2, 8'hEA, 8'hE2};

    via_arbiter dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_cycle_i(icyc), .ir_load_i(ir_load),
        .ir_byte_i(ir_byte), .vector_select_instr_i(vs), .clear_trap_pending_instr_i(clr), .pc_i(pc_i),
        .opcode_addr_i(op_addr), .stack_pop_i(pop), .stack_ptr_i(sp), .pm_valid_i(pm_valid),
        .pm_data_i(pm_data), .pm_data_o(pm_byte), .pm_addr_o(pm_addr), .pm_rd_o(pm_rd), .src_pending_i(pend),
        .src_enable_i(enb), .global_irq_enable_i(global_irq_enable), .trap_take_o(take), .push_addr_o(push_addr),
        .irq_ack_o(ack), .global_irq_enable_clr_o(gie_clr), .pc_load_o(pc_load), .pc_o(pc_o), .busy_o(busy));
    via_pm_model #(.MEM_TOP(MEM_TOP)) pm_u (.ref_clk_i(ref_clk_i), .lat_i(lat), .pm_rd_i(pm_rd),
        .pm_addr_i(pm_addr), .pm_valid_o(pm_valid), .pm_data_o(pm_data));

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits a bounded number of cycles for pm_rd_o (rd set) or pc_load_o.
    task automatic wait_hi(input bit rd, input int lim);
        int n;
        n = 0;
        while ((rd ? pm_rd : pc_load) !== 1'b1) begin
            @(posedge ref_clk_i);
            #1;
            n++;
            if (n > lim) begin
                check(rd ? "pm_rd wait" : "pc_load wait", 16'h0, 16'h1);
                print_verdict();
            end
        end
    endtask

    // Strobe 0 clears the trap flag, 1 marks an instruction cycle, 2 pops the stack.
    task automatic strobe(input int which);
        @(posedge ref_clk_i);
        clr <= (which == 0);
        icyc <= (which == 1);
        pop <= (which == 2);
        @(posedge ref_clk_i);
        clr <= 1'b0;
        icyc <= 1'b0;
        pop <= 1'b0;
        #1;
    endtask

    task automatic fetch(input logic [7:0] b, input logic [14:0] a);
        @(posedge ref_clk_i);
        ir_load <= 1'b1;
        ir_byte <= b;
        op_addr <= a;
        @(posedge ref_clk_i);
        ir_load <= 1'b0;
        #1;
        check("trap take", take, b == 8'h00);
    endtask

    function automatic logic [14:0] exp_vec(input logic [14:0] a);
        logic [7:0] hi, lo;
        hi = a[7:0] ^ 8'h5A;
        lo = (a[7:0] | 8'h01) ^ 8'h5A;
        if (a > MEM_TOP)
            return 15'h0000;
        return {hi[6:0], lo};
    endfunction

    task automatic do_vs(input logic [14:0] pc, input logic [7:0] off);
        logic [14:0] ptr;
        ptr = {pc[14:8] + ((pc[7:0] == 8'hFF) ? 7'h01 : 7'h00), off};
        @(posedge ref_clk_i);
        pc_i <= pc;
        vs <= 1'b1;
        @(posedge ref_clk_i);
        vs <= 1'b0;
        #1;
        wait_hi(1'b1, 4);
        check("vector pointer", pm_addr, ptr);
        wait_hi(1'b0, 40);
        check("vector", pc_o, exp_vec(ptr));
    endtask

    task automatic t_basic();
        check("idle outputs", {busy, take, ack, gie_clr, pc_load}, 5'h00);
        check("erased byte", pm_byte, 8'h00);
        do_vs(15'h0123, 8'hE0);
        lat <= 4'h3;
        do_vs(15'h00FF, 8'hE0);
        do_vs(15'h7F10, 8'hE0);
        lat <= 4'h0;
        $display("basic done");
    endtask

    task automatic t_rank();
        enb <= 7'h7F;
        for (int i = 0; i < 7; i++) begin
            pend <= 7'h7F >> i;
            do_vs(15'h0340, offs[i]);
        end
        enb <= 7'h00;
        do_vs(15'h0340, 8'hE0);
        enb <= 7'h7F;
        pend <= 7'h40;
        $display("rank done");
    endtask

    task automatic t_trap();
        fetch(8'h01, 15'h1233);
        fetch(8'h00, 15'h1234);
        check("trap push", push_addr, 15'h1234);
        check("enable kept", gie_clr, 1'b0);
        strobe(1);
        check("ack refused", ack, 1'b0);
        do_vs(15'h0500, 8'hFE);
        fetch(8'h00, 15'h1300);
        strobe(0);
        do_vs(15'h0500, 8'hFA);
        $display("trap done");
    endtask

    task automatic t_ack();
        int n;
        pc_i <= 15'h0456;
        strobe(1);
        check("ack", {ack, gie_clr}, 2'h3);
        check("ack push", push_addr, 15'h0456);
        n = 0;
        while (pc_load !== 1'b1 && n < 12) begin
            strobe(1);
            n++;
            if (pc_load !== 1'b1) begin
                @(posedge ref_clk_i);
                #1;
            end
        end
        check("ack cycles", 16'(n), 16'h0007);
        check("ack target", pc_o, 15'h00FF);
        pend <= 7'h00;
        strobe(0);
        strobe(0);
        do_vs(15'h0600, 8'hE0);
        $display("ack done");
    endtask

    task automatic t_stack();
        sp <= 8'h6F;
        strobe(2);
        check("no underflow", pc_load, 1'b0);
        sp <= 8'h70;
        strobe(2);
        wait_hi(1'b0, 3);
        check("underflow pc", pc_o, 15'h7FFF);
        $display("stack done");
    endtask

    // A mid-run reset must drop a pending trap, so the next selection falls back to the default vector.
    task automatic t_reset();
        fetch(8'h00, 15'h0700);
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        check("reset outputs", {busy, take, ack, gie_clr, pc_load}, 5'h00);
        do_vs(15'h0800, 8'hE0);
        $display("reset done");
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        {rst_i, global_irq_enable} = 2'b11;
        {icyc, ir_load, vs, clr, pop} = 5'h00;
        {ir_byte, sp, pc_i, op_addr, lat} = '0;
        pend = 7'h00;
        enb = 7'h00;
        fail_count = 0;
        cmp_count = 0;
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        t_basic();
        t_rank();
        t_trap();
        t_ack();
        t_stack();
        t_reset();
        print_verdict();
    end
endmodule // testbench

// [dv/via_pm_model.sv]
// Program memory fetch path model that answers vector byte reads.
`timescale 1ns/10ps
module via_pm_model #(
    parameter logic [14:0] MEM_TOP = 15'h3FFF
) (
    // Clock and latency.
    input wire logic ref_clk_i,
    input wire logic [3:0] lat_i,
    // Fetch path.
    input wire logic pm_rd_i,
    input wire logic [14:0] pm_addr_i,
    output logic pm_valid_o,
    output logic [7:0] pm_data_o
);
    logic [3:0] wait_q;
    initial begin
        pm_valid_o = 1'b0;
        pm_data_o = 8'hA5;
        wait_q = 4'h0;
    end
    // A released data bus toggles so that stale bytes are never mistaken for answers.
    always @(posedge ref_clk_i) begin
        if (pm_rd_i && !pm_valid_o && wait_q >= lat_i) begin
            pm_valid_o <= 1'b1;
            pm_data_o <= (pm_addr_i > MEM_TOP) ? 8'h00 : (pm_addr_i[7:0] ^ 8'h5A);
            wait_q <= 4'h0;
        end else begin
            pm_valid_o <= 1'b0;
            pm_data_o <= ~pm_data_o;
            wait_q <= (pm_rd_i && !pm_valid_o) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule // via_pm_model

// [hw/via_arbiter.sv]
// Vectored interrupt arbiter with trap pending flag and vector fetch.
// What this block does
// - Ranks trap, reserved, pin, idle timer, timer1 A/B, serial, capture, port L, default.
// - The vector select instruction latches an even E0..FE offset on its first cycle.
// - The offset replaces only the low program counter byte.
// - Two vector bytes are read and loaded into the program counter.
// - Vector table sits in the instruction's block, or the next one at last address.
// - The trap pending flag has no data memory read or write path.
// - Reset clears the trap pending flag.
// - A trap sets the trap pending flag.
// - The clear trap pending instruction clears the flag unless a trap fetch in the same cycle sets it; only reset also clears it.
// - Fetching the trap opcode into the instruction register raises a trap.
// - Nonexistent program memory reads as zeros, the trap opcode.
// - Popping below the stack floor loads 7FFF into the program counter.
// - Trap keeps the global enable; pending trap blocks others and selects trap vector.
// - During a trap routine no maskable request is acknowledged.
// - The trap pushes the address of the trap opcode itself.
// - The pending flag is one bit, not a nesting counter.
// - Clearing an already clear flag has no side effect.
// - With nothing active the default offset is produced.
// - Vector high byte sits at the even address, low byte at the odd one.
// - Maskable acknowledge clears the enable, pushes next address, jumps to 00FF in seven cycles.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module via_arbiter (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Instruction sequencer, one-cycle instruction strobes.
    input wire logic instr_cycle_i,
    input wire logic ir_load_i,
    input wire logic [7:0] ir_byte_i,
    input wire logic vector_select_instr_i,
    input wire logic clear_trap_pending_instr_i,
    input wire logic [14:0] pc_i,
    input wire logic [14:0] opcode_addr_i,
    // Stack pop check.
    input wire logic stack_pop_i,
    input wire logic [7:0] stack_ptr_i,
    // Program memory fetch path.
    input wire logic pm_valid_i,
    input wire logic [7:0] pm_data_i,
    output logic [7:0] pm_data_o,
    output logic [14:0] pm_addr_o,
    output logic pm_rd_o,
    // Maskable sources.
    input wire via_pkg::via_src_t src_pending_i,
    input wire via_pkg::via_src_t src_enable_i,
    input wire logic global_irq_enable_i,
    // Sequencer outputs.
    output logic trap_take_o,
    output logic [14:0] push_addr_o,
    output logic irq_ack_o,
    output logic global_irq_enable_clr_o,
    output logic pc_load_o,
    output logic [14:0] pc_o,
    output logic busy_o
);
    logic trap_pending_flag_q, trap_pending_flag_d;
    via_pkg::via_state_t state_q, state_d;
    logic [7:0] offset_q, offset_d;
    logic [7:0] hi_q, hi_d;
    logic [14:0] ptr_q, ptr_d;
    logic [14:0] pc_q, pc_d;
    logic pc_load_q, pc_load_d;
    logic [14:0] push_q, push_d;
    logic trap_take_q, trap_take_d;
    logic ack_q, ack_d;
    logic [2:0] ack_cnt_q, ack_cnt_d;
    logic [15:0] active;
    logic [7:0] offset;
    logic trap_fetch;
    logic [14:0] base;

    // Missing program memory returns zeros, which decode as the trap opcode.
    assign pm_data_o = pm_valid_i ? pm_data_i : via_pkg::ERASED_BYTE;
    assign trap_fetch = ir_load_i && ir_byte_i == via_pkg::TRAP_OPCODE;

    // The flag lives only here and has no software port.
    always_comb begin
        trap_pending_flag_d = trap_pending_flag_q;
        if (clear_trap_pending_instr_i) begin
            trap_pending_flag_d = 1'b0;
        end
        if (trap_fetch) begin
            trap_pending_flag_d = 1'b1;
        end
    end

    always_comb begin
        active = '0;
        active[via_pkg::SLOT_TRAP] = trap_pending_flag_q;
        if (!trap_pending_flag_q) begin
            active[via_pkg::SLOT_EXT] = src_pending_i.external_irq_pin & src_enable_i.external_irq_pin;
            active[via_pkg::SLOT_IDLE] = src_pending_i.idle_timer & src_enable_i.idle_timer;
            active[via_pkg::SLOT_T1A] = src_pending_i.timer1_a_event & src_enable_i.timer1_a_event;
            active[via_pkg::SLOT_T1B] = src_pending_i.timer1_b_event & src_enable_i.timer1_b_event;
            active[via_pkg::SLOT_SERIAL] = src_pending_i.serial_busy_low & src_enable_i.serial_busy_low;
            active[via_pkg::SLOT_CAPTURE] = src_pending_i.capture_timer & src_enable_i.capture_timer;
            active[via_pkg::SLOT_PORTL] = src_pending_i.port_l_edge & src_enable_i.port_l_edge;
        end
        active = active & (via_pkg::MASKABLE_SLOTS | 16'h8000);
    end

    // Highest index wins; none active gives the default offset.
    via_rank u_rank (
        .active_i(active),
        .offset_o(offset)
    );

    // Table lives in the current block unless the instruction is at the block's last byte.
    assign base = (pc_i[7:0] == 8'hFF) ? pc_i + 15'h0001 : pc_i;

    always_comb begin
        state_d = state_q;
        offset_d = offset_q;
        hi_d = hi_q;
        ptr_d = ptr_q;
        pc_d = pc_q;
        pc_load_d = 1'b0;
        push_d = push_q;
        trap_take_d = 1'b0;
        ack_d = 1'b0;
        ack_cnt_d = ack_cnt_q;
        if (trap_fetch) begin
            trap_take_d = 1'b1;
            push_d = opcode_addr_i;
        end
        if (stack_pop_i && stack_ptr_i > via_pkg::STACK_FLOOR) begin
            pc_d = via_pkg::PC_STACK_UNDERFLOW;
            pc_load_d = 1'b1;
        end
        unique case (state_q)
            via_pkg::VIA_IDLE: begin
                if (vector_select_instr_i) begin
                    offset_d = offset;
                    ptr_d = {base[14:8], offset};
                    state_d = via_pkg::VIA_HI;
                end else if (instr_cycle_i && global_irq_enable_i && !trap_pending_flag_q
                             && !trap_fetch && (active & via_pkg::MASKABLE_SLOTS) != '0) begin
                    push_d = pc_i;
                    ack_d = 1'b1;
                    ack_cnt_d = via_pkg::ACK_CYCLES;
                    state_d = via_pkg::VIA_ACK;
                end
            end
            via_pkg::VIA_HI: begin
                if (pm_valid_i) begin
                    hi_d = pm_data_o;
                    ptr_d = ptr_q + 15'h0001;
                    state_d = via_pkg::VIA_LO;
                end
            end
            via_pkg::VIA_LO: begin
                if (pm_valid_i) begin
                    pc_d = {hi_q[6:0], pm_data_o};
                    pc_load_d = 1'b1;
                    state_d = via_pkg::VIA_IDLE;
                end
            end
            via_pkg::VIA_ACK: begin
                if (instr_cycle_i) begin
                    ack_cnt_d = ack_cnt_q - 3'h1;
                    if (ack_cnt_q == 3'h1) begin
                        pc_d = via_pkg::PC_ACK;
                        pc_load_d = 1'b1;
                        state_d = via_pkg::VIA_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trap_pending_flag_q <= 1'b0;
            state_q <= via_pkg::VIA_IDLE;
            offset_q <= via_pkg::OFS_DEFAULT;
            hi_q <= 8'h00;
            ptr_q <= 15'h0000;
            pc_q <= 15'h0000;
            pc_load_q <= 1'b0;
            push_q <= 15'h0000;
            trap_take_q <= 1'b0;
            ack_q <= 1'b0;
            ack_cnt_q <= via_pkg::ACK_CNT_RESET;
        end else begin
            trap_pending_flag_q <= trap_pending_flag_d;
            state_q <= state_d;
            offset_q <= offset_d;
            hi_q <= hi_d;
            ptr_q <= ptr_d;
            pc_q <= pc_d;
            pc_load_q <= pc_load_d;
            push_q <= push_d;
            trap_take_q <= trap_take_d;
            ack_q <= ack_d;
            ack_cnt_q <= ack_cnt_d;
        end
    end

    assign pm_addr_o = ptr_q;
    assign pm_rd_o = state_q == via_pkg::VIA_HI || state_q == via_pkg::VIA_LO;
    assign pc_o = pc_q;
    assign pc_load_o = pc_load_q;
    assign push_addr_o = push_q;
    assign trap_take_o = trap_take_q;
    assign irq_ack_o = ack_q;
    assign global_irq_enable_clr_o = ack_q;
    assign busy_o = state_q != via_pkg::VIA_IDLE;

    // Checks.
    property p_flag_set;
        @(posedge ref_clk_i) disable iff (rst_i) trap_fetch |=> trap_pending_flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("trap fetch did not set flag");

    property p_flag_clr;
        @(posedge ref_clk_i) disable iff (rst_i) clear_trap_pending_instr_i && !trap_fetch |=> !trap_pending_flag_q;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("clear did not clear flag");

    property p_flag_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
            !clear_trap_pending_instr_i && !trap_fetch |=> trap_pending_flag_q == $past(trap_pending_flag_q);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag changed without cause");

    property p_trap_vec;
        @(posedge ref_clk_i) disable iff (rst_i)
            state_q == via_pkg::VIA_IDLE && vector_select_instr_i && trap_pending_flag_q
            |=> offset_q == via_pkg::OFS_TRAP;
    endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("trap vector not selected");

    property p_default_vec;
        @(posedge ref_clk_i) disable iff (rst_i)
            state_q == via_pkg::VIA_IDLE && vector_select_instr_i && active == '0
            |=> offset_q == via_pkg::OFS_DEFAULT;
    endproperty
    a_default_vec: assert property (p_default_vec) else $error("default vector not selected");

    property p_no_ack_in_trap;
        @(posedge ref_clk_i) disable iff (rst_i) trap_pending_flag_q |=> !irq_ack_o;
    endproperty
    a_no_ack_in_trap: assert property (p_no_ack_in_trap) else $error("maskable acked during trap");

    property p_ptr_high;
        @(posedge ref_clk_i) disable iff (rst_i)
            state_q == via_pkg::VIA_IDLE && vector_select_instr_i && pc_i[7:0] != 8'hFF
            |=> pm_addr_o[14:8] == $past(pc_i[14:8]) && pm_addr_o[7:0] == offset_q;
    endproperty
    a_ptr_high: assert property (p_ptr_high) else $error("vector pointer wrong");

    property p_even;
        @(posedge ref_clk_i) disable iff (rst_i) offset_q[0] == 1'b0 && offset_q >= via_pkg::OFS_DEFAULT;
    endproperty
    a_even: assert property (p_even) else $error("offset odd or out of range");

    property p_underflow;
        @(posedge ref_clk_i) disable iff (rst_i)
            stack_pop_i && stack_ptr_i > via_pkg::STACK_FLOOR && state_q == via_pkg::VIA_IDLE && !vector_select_instr_i
            && !(instr_cycle_i && global_irq_enable_i && !trap_pending_flag_q && (active & via_pkg::MASKABLE_SLOTS) != '0)
            |=> pc_load_o && pc_o == via_pkg::PC_STACK_UNDERFLOW;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow jump missing");

    property p_trap_push;
        @(posedge ref_clk_i) disable iff (rst_i)
            trap_fetch |=> trap_take_o && push_addr_o == $past(opcode_addr_i);
    endproperty
    a_trap_push: assert property (p_trap_push) else $error("trap did not push its own address");

    property p_ack_start;
        @(posedge ref_clk_i) disable iff (rst_i)
            state_q == via_pkg::VIA_IDLE && !vector_select_instr_i && instr_cycle_i && global_irq_enable_i
            && !trap_pending_flag_q && !trap_fetch && (active & via_pkg::MASKABLE_SLOTS) != '0
            |=> irq_ack_o && global_irq_enable_clr_o && push_addr_o == $past(pc_i);
    endproperty
    a_ack_start: assert property (p_ack_start) else $error("maskable acknowledge start wrong");

    property p_ack_load;
        @(posedge ref_clk_i) disable iff (rst_i)
            state_q == via_pkg::VIA_ACK && instr_cycle_i && ack_cnt_q == 3'h1
            |=> pc_load_o && pc_o == via_pkg::PC_ACK;
    endproperty
    a_ack_load: assert property (p_ack_load) else $error("acknowledge jump missing");

    property p_vec_load;
        @(posedge ref_clk_i) disable iff (rst_i)
            state_q == via_pkg::VIA_LO && pm_valid_i |=> pc_load_o && pc_o[7:0] == $past(pm_data_i);
    endproperty
    a_vec_load: assert property (p_vec_load) else $error("vector low byte not loaded");

    property p_ptr_next_block;
        @(posedge ref_clk_i) disable iff (rst_i)
            state_q == via_pkg::VIA_IDLE && vector_select_instr_i && pc_i[7:0] == 8'hFF
            |=> pm_addr_o[14:8] == $past(pc_i[14:8]) + 7'h01;
    endproperty
    a_ptr_next_block: assert property (p_ptr_next_block) else $error("vector table block wrong");

    c_trap: cover property (@(posedge ref_clk_i) disable iff (rst_i) trap_fetch);
    c_vis: cover property (@(posedge ref_clk_i) disable iff (rst_i) pc_load_o && state_q == via_pkg::VIA_IDLE);
    c_ack: cover property (@(posedge ref_clk_i) disable iff (rst_i) irq_ack_o);
    c_underflow: cover property (@(posedge ref_clk_i) disable iff (rst_i) pc_load_o && pc_o == via_pkg::PC_STACK_UNDERFLOW);
endmodule // via_arbiter

// [hw/via_pkg.sv]
// Package of constants and types for the vectored interrupt arbiter.
package via_pkg;

    // Instruction opcodes seen by the arbiter.
    localparam logic [7:0] TRAP_OPCODE = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'h00;

    // Vector offsets.
    localparam logic [7:0] OFS_TRAP = 8'hFE;
    localparam logic [7:0] OFS_DEFAULT = 8'hE0;
    localparam int NUM_SLOTS = 16;

    // Ranking slots, index 15 highest; reserved slots never become active.
    localparam int SLOT_TRAP = 15;
    localparam int SLOT_EXT = 13;
    localparam int SLOT_IDLE = 12;
    localparam int SLOT_T1A = 11;
    localparam int SLOT_T1B = 10;
    localparam int SLOT_SERIAL = 9;
    localparam int SLOT_CAPTURE = 5;
    localparam int SLOT_PORTL = 1;
    localparam logic [15:0] MASKABLE_SLOTS = 16'h3E22;

    // Program counter values.
    localparam logic [14:0] PC_ACK = 15'h00FF;
    localparam logic [14:0] PC_STACK_UNDERFLOW = 15'h7FFF;
    localparam logic [7:0] STACK_FLOOR = 8'h6F;

    // Maskable acknowledge length in instruction cycles.
    localparam logic [2:0] ACK_CYCLES = 3'h7;
    localparam logic [2:0] ACK_CNT_RESET = 3'h0;

    // Maskable source levels.
    typedef struct packed {
        logic external_irq_pin;
        logic idle_timer;
        logic timer1_a_event;
        logic timer1_b_event;
        logic serial_busy_low;
        logic capture_timer;
        logic port_l_edge;
    } via_src_t;

    // Sequencer states; Gray codes along idle, high byte, low byte, acknowledge.
    typedef enum logic [1:0] {
        VIA_IDLE = 2'h0,
        VIA_HI = 2'h1,
        VIA_LO = 2'h3,
        VIA_ACK = 2'h2
    } via_state_t;

endpackage

// [hw/via_rank.sv]
// Fixed-priority encoder turning active slots into an even vector offset.
`timescale 1ns/10ps
module via_rank (
    // Slot activity.
    input wire logic [15:0] active_i,
    // Result.
    output logic [7:0] offset_o
);
    always_comb begin
        offset_o = via_pkg::OFS_DEFAULT;
        for (int i = 0; i < via_pkg::NUM_SLOTS; i++) begin
            if (active_i[i]) begin
                offset_o = via_pkg::OFS_DEFAULT + 8'(2 * i);
            end
        end
    end
endmodule // via_rank
